// File: lrsam_pkg.sv
package lrsam_pkg;

    // Reference clock and internal oscillator
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned OSC_HZ          = 1536;
    localparam int unsigned OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
    localparam int unsigned OSC_CNT_W       = 17;

    // Frame timing: one frame is this many selected clock periods
    localparam int unsigned FRAME_DIV = 24;
    localparam logic [4:0]  LEN_STATIC = 5'(FRAME_DIV / 1);
    localparam logic [4:0]  LEN_TWO    = 5'(FRAME_DIV / 2);
    localparam logic [4:0]  LEN_THREE  = 5'(FRAME_DIV / 3);
    localparam logic [4:0]  LEN_FOUR   = 5'(FRAME_DIV / 4);

    // Display memory geometry
    localparam int unsigned     RAM_WORDS = 40;
    localparam logic [5:0]      LAST_ADDR = 6'h27;
    localparam logic [5:0]      WORDS6    = 6'h28;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_POINTER = 8'h04;
    localparam logic [7:0] OFS_DATA    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;

    // CTRL fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_BIAS     = 2;
    localparam int unsigned CTRL_ENABLE   = 3;
    localparam int unsigned CTRL_IN_BANK  = 4;
    localparam int unsigned CTRL_OUT_BANK = 5;
    // POINTER fields
    localparam int unsigned PTR_ADDR_LSB  = 0;
    localparam int unsigned PTR_SUB_LSB   = 8;

    typedef enum logic [1:0] {
        MODE_STATIC = 2'h0,
        MODE_TWO    = 2'h1,
        MODE_THREE  = 2'h2,
        MODE_FOUR   = 2'h3
    } lrsam_mode_e;

    // Reset values
    localparam lrsam_mode_e RST_MODE = MODE_FOUR;
    localparam logic        RST_BIAS = 1'b0;

    // Drive level codes; in half bias LVL_LOW is the mid level
    localparam logic [1:0] LVL_VSS  = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_VLCD = 2'h3;

    typedef struct packed {
        lrsam_mode_e           mode;
        logic                  biasThird;
        logic                  dispEn;
        logic                  inBank;
        logic                  outBank;
        logic [5:0]            ptr;
        logic [2:0]            subCnt;
        logic [39:0][3:0]      ram;
        logic [39:0]           latch;
        logic [1:0]            phase;
        logic [4:0]            tickCnt;
        logic                  polarity;
        logic [OSC_CNT_W-1:0]  oscCnt;
        logic                  oscLevel;
        logic                  clkOe;
        logic                  clkPrev;
        logic                  syncPrev;
        logic                  syncDrive;
        logic [3:0][1:0]       bp;
        logic [39:0][1:0]      seg;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } lrsam_state_s;

endpackage : lrsam_pkg

// File: lrsam_core.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Frame rate is the selected clock divided by 24.
// R2: Select high takes the clock pin as input; low drives internal oscillator out.
// R3: The clock must keep running; without it outputs freeze at DC.
// R4: Serial data line is held high after power-on so the oscillator starts.
// R5: Cascade sync keeps multiplex timing aligned across drivers.
// R6: Display memory is 40 words of 4 bits; 1 means segment on.
// R7: Column k drives segment k; row r is multiplexed with backplane r.
// R8: Each display byte is stored at once on arrival.
// R9: Static mode puts the byte into row 0 of eight addresses.
// R10: Two-backplane mode fills rows 0 and 1 of four addresses.
// R11: Three-backplane mode fills rows 0 to 2 of three addresses; last bit 2 kept.
// R12: Four-backplane mode fills rows 0 to 3 of two addresses.
// R13: Pointer advances by 8, 4, 3 or 2 per byte; load sets its start.
// R14: Host reloads the pointer after a write that was cut short.
// R15: Scan visits bits 0..n-1 in turn for the mode in use.
// R16: Sync resets the scan to bit 0, 1, 2 or 3 by mode.
// R17: Output bank shows bits 2/3 instead of 0/1 in static and two modes.
// R18: Input bank writes bits 2/3 instead of 0/1 in static and two modes.
// R19: Input and output bank choices are held independently.
// R20: The latch holds one bit per column steady through each phase; the code reloads it from memory on every tick.
// R21: Three mode copies backplane 1 to 3; two mode pairs 0/2 and 1/3.
// R22: Static mode drives one waveform on all four backplanes.
// R23: Two-backplane mode supports half or third bias.
// R24: Reset gives four-backplane, half bias, banks, pointer, counter cleared, display off.
// R25: Foreign subaddress blocks storage but pointer moves; overflow bumps the counter.
// R26: Byte bits go MSB first into lowest row at the pointer first.
// R27: Pointer spans 0 to 39 and wraps to 0; the code wraps modulo 40, so 38 stepped by 4 lands on 2.
module lrsam_core #(
    parameter int unsigned OSC_HALF = lrsam_pkg::OSC_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Straps
    input  wire logic        osc_source_select,
    input  wire logic [2:0]  hwSubaddr,
    // Clock pin
    input  wire logic        clkPinIn,
    output logic             clkPinOut,
    output logic             clkPinOe,
    // Cascade sync pin, open drain, low is active
    input  wire logic        syncIn_n,
    output logic             syncOut_n,
    output logic             syncOe,
    // LCD drive level codes
    output logic [3:0][1:0]  backplane_outputs,
    output logic [39:0][1:0] segment_outputs
);
    import lrsam_pkg::*;

    lrsam_state_s s;
    lrsam_state_s next_s;

    function automatic logic [2:0] stepOf(input lrsam_mode_e m);
        unique case (m)
            MODE_STATIC: stepOf = 3'h0; // eight: carried as 0 + 8 below
            MODE_TWO:    stepOf = 3'h4;
            MODE_THREE:  stepOf = 3'h3;
            MODE_FOUR:   stepOf = 3'h2;
        endcase
    endfunction : stepOf

    function automatic logic [3:0] stepFull(input lrsam_mode_e m);
        stepFull = (m == MODE_STATIC) ? 4'h8 : {1'b0, stepOf(m)};
    endfunction : stepFull

    function automatic logic [4:0] phaseLen(input lrsam_mode_e m);
        unique case (m)
            MODE_STATIC: phaseLen = LEN_STATIC;
            MODE_TWO:    phaseLen = LEN_TWO;
            MODE_THREE:  phaseLen = LEN_THREE;
            MODE_FOUR:   phaseLen = LEN_FOUR;
        endcase
    endfunction : phaseLen

    function automatic logic bpActive(input lrsam_mode_e m, input logic [1:0] r,
                                      input logic [1:0] ph);
        unique case (m)
            MODE_STATIC: bpActive = 1'b1;
            MODE_TWO:    bpActive = (r[0] == ph[0]);
            MODE_THREE:  bpActive = (((r == 2'h3) ? 2'h1 : r) == ph);
            MODE_FOUR:   bpActive = (r == ph);
        endcase
    endfunction : bpActive

    // Row that a received bit lands in; rows beyond 3 never occur
    function automatic logic [1:0] bitRow(input lrsam_mode_e m, input logic [2:0] j,
                                          input logic bank);
        unique case (m)
            MODE_STATIC: bitRow = bank ? 2'h2 : 2'h0;                   // [R9] [R18]
            MODE_TWO:    bitRow = {bank, j[0]};                         // [R10] [R18]
            MODE_THREE:  bitRow = 2'(j % 3'h3);                         // [R11]
            MODE_FOUR:   bitRow = j[1:0];                               // [R12]
        endcase
    endfunction : bitRow

    function automatic logic [2:0] bitOffset(input lrsam_mode_e m, input logic [2:0] j);
        unique case (m)
            MODE_STATIC: bitOffset = j;
            MODE_TWO:    bitOffset = {1'b0, j[2:1]};
            MODE_THREE:  bitOffset = 3'(j / 3'h3);
            MODE_FOUR:   bitOffset = {2'h0, j[2]};
        endcase
    endfunction : bitOffset

    function automatic logic [1:0] regSel(input logic [7:0] a, output logic hit);
        hit = 1'b1;
        unique case (a)
            OFS_CTRL:    regSel = 2'h0;
            OFS_POINTER: regSel = 2'h1;
            OFS_DATA:    regSel = 2'h2;
            OFS_STATUS:  regSel = 2'h3;
            default: begin
                regSel = 2'h0;
                hit    = 1'b0;
            end
        endcase
    endfunction : regSel

    logic        setupPh;
    logic        accessWr;
    logic        hitSetup;
    logic        hitAcc;
    logic [1:0]  selSetup;
    logic [1:0]  selAcc;
    logic        dataWr;
    logic        tick;
    logic        syncFall;
    logic [1:0]  lastPhase;
    logic [1:0]  scanRow;
    logic [6:0]  ptrSum;
    logic [6:0]  bitAddr;
    logic [5:0]  wrAddr;
    logic [2:0]  wrSub;
    logic [1:0]  wrRow;
    logic [1:0]  lvl;
    logic [5:0]  ptrLoad;

    always_comb begin
        next_s   = s;
        setupPh  = psel && !penable;
        accessWr = psel && penable && s.pready && pwrite;
        selSetup = regSel(paddr, hitSetup);
        selAcc   = regSel(paddr, hitAcc);
        dataWr   = accessWr && hitAcc && (selAcc == 2'h2);
        ptrSum   = 7'h0;
        bitAddr  = 7'h0;
        wrAddr   = 6'h0;
        wrSub    = 3'h0;
        wrRow    = 2'h0;
        lvl      = LVL_VLCD;
        ptrLoad  = 6'h0;

        // APB: no wait state, answer prepared during setup
        next_s.pready  = setupPh;
        next_s.pslverr = setupPh && !hitSetup;
        next_s.prdata  = 32'h0;
        if (setupPh && !pwrite && hitSetup) begin
            unique case (selSetup)
                2'h0: next_s.prdata = {26'h0, s.outBank, s.inBank, s.dispEn,
                                       s.biasThird, s.mode};
                2'h1: next_s.prdata = {21'h0, s.subCnt, 2'h0, s.ptr};
                2'h2: next_s.prdata = 32'h0;
                2'h3: next_s.prdata = {29'h0, s.polarity, s.phase};
            endcase
        end

        if (accessWr && hitAcc && selAcc == 2'h0) begin
            next_s.mode      = lrsam_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
            next_s.biasThird = pwdata[CTRL_BIAS];                       // [R23]
            next_s.dispEn    = pwdata[CTRL_ENABLE];
            next_s.inBank    = pwdata[CTRL_IN_BANK];                    // [R19]
            next_s.outBank   = pwdata[CTRL_OUT_BANK];                   // [R19]
        end
        if (accessWr && hitAcc && selAcc == 2'h1) begin
            // Out-of-range loads land on address 0
            ptrLoad       = pwdata[PTR_ADDR_LSB +: 6];
            next_s.ptr    = (ptrLoad > LAST_ADDR) ? 6'h0 : ptrLoad;     // [R13] [R27]
            next_s.subCnt = pwdata[PTR_SUB_LSB +: 3];
        end

        // Byte stored in the access cycle itself, no later handshake
        if (dataWr) begin                                               // [R8]
            for (int i = 0; i < 8; i++) begin
                // Bit 7 goes first, lowest row at the pointer
                bitAddr = {1'b0, s.ptr} + {4'h0, bitOffset(s.mode, 3'(7 - i))}; // [R26]
                wrRow   = bitRow(s.mode, 3'(7 - i), s.inBank);
                if (bitAddr > {1'b0, LAST_ADDR}) begin
                    wrAddr = 6'(bitAddr - {1'b0, WORDS6});
                    wrSub  = s.subCnt + 3'h1;
                end else begin
                    wrAddr = bitAddr[5:0];
                    wrSub  = s.subCnt;
                end
                if (wrSub == hwSubaddr) begin                           // [R25]
                    next_s.ram[wrAddr][wrRow] = pwdata[i];              // [R6] [R7]
                end
            end
            ptrSum = {1'b0, s.ptr} + {3'h0, stepFull(s.mode)};          // [R13]
            if (ptrSum > {1'b0, LAST_ADDR}) begin
                next_s.ptr    = 6'(ptrSum - {1'b0, WORDS6});            // [R27]
                next_s.subCnt = s.subCnt + 3'h1;                        // [R25]
            end else begin
                next_s.ptr = ptrSum[5:0];
            end
        end

        // Clock source: internal divider or clock pin edge
        next_s.clkPrev = clkPinIn;
        // Registered so the pin enable leaves straight from a flop
        next_s.clkOe   = !osc_source_select;                            // [R2]
        if (s.oscCnt == OSC_CNT_W'(OSC_HALF - 1)) begin
            next_s.oscCnt   = '0;
            next_s.oscLevel = !s.oscLevel;
        end else begin
            next_s.oscCnt = s.oscCnt + OSC_CNT_W'(1);
        end
        if (osc_source_select) begin                                    // [R2]
            tick = clkPinIn && !s.clkPrev;
        end else begin
            tick = (s.oscCnt == OSC_CNT_W'(OSC_HALF - 1)) && !s.oscLevel;
        end

        // Scan sequencing, each phase lasts 24/n ticks
        lastPhase       = 2'(s.mode);
        next_s.syncPrev = syncIn_n;
        syncFall        = !syncIn_n && s.syncPrev && !s.syncDrive;
        if (tick) begin
            next_s.syncDrive = 1'b0;
            if (s.tickCnt >= phaseLen(s.mode) - 5'h1) begin             // [R1]
                next_s.tickCnt = 5'h0;
                if (s.phase >= lastPhase) begin                         // [R15]
                    next_s.phase     = 2'h0;
                    next_s.polarity  = !s.polarity;
                    next_s.syncDrive = 1'b1;                            // [R5]
                end else begin
                    next_s.phase = s.phase + 2'h1;
                end
            end else begin
                next_s.tickCnt = s.tickCnt + 5'h1;
            end
        end
        if (syncFall) begin                                             // [R5] [R16]
            next_s.phase   = lastPhase;
            next_s.tickCnt = 5'h0;
        end

        // Latch and drive levels change only on a tick, so a dead clock freezes them
        scanRow = next_s.phase;
        if (s.outBank && (s.mode == MODE_STATIC || s.mode == MODE_TWO)) begin
            scanRow = next_s.phase | 2'h2;                              // [R17]
        end
        if (tick) begin
            for (int k = 0; k < RAM_WORDS; k++) begin
                next_s.latch[k] = s.ram[k][scanRow];                    // [R20] [R7]
            end
            for (int r = 0; r < 4; r++) begin
                if (bpActive(s.mode, 2'(r), next_s.phase)) begin        // [R21] [R22]
                    lvl = LVL_VLCD;
                end else begin
                    lvl = LVL_LOW;
                end
                if (next_s.polarity && !(lvl == LVL_LOW && !s.biasThird)) begin
                    lvl = ~lvl;
                end
                next_s.bp[r] = s.dispEn ? lvl : LVL_VLCD;
            end
            for (int k = 0; k < RAM_WORDS; k++) begin
                if (next_s.latch[k]) begin
                    lvl = LVL_VSS;
                end else if (s.biasThird && s.mode != MODE_STATIC) begin
                    lvl = LVL_HIGH;                                     // [R23]
                end else begin
                    lvl = LVL_VLCD;
                end
                if (next_s.polarity) begin
                    lvl = ~lvl;
                end
                next_s.seg[k] = s.dispEn ? lvl : LVL_VLCD;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s           <= '0;
            s.mode      <= RST_MODE;                                    // [R24]
            s.biasThird <= RST_BIAS;
            s.bp        <= {4{LVL_VLCD}};
            s.seg       <= {40{LVL_VLCD}};
            s.syncPrev  <= 1'b1;
            s.clkPrev   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign pready            = s.pready;
    assign prdata            = s.prdata;
    assign pslverr           = s.pslverr;
    assign clkPinOut         = s.oscLevel;
    assign clkPinOe          = s.clkOe;
    assign syncOut_n         = 1'b0;
    assign syncOe            = s.syncDrive;
    assign backplane_outputs = s.bp;
    assign segment_outputs   = s.seg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    ptr_range_a: assert property (s.ptr <= LAST_ADDR) // [R27]
        else $error("pointer left 0..39");
    ptr_step_a: assert property (dataWr
        && ({1'b0, s.ptr} + 7'(stepFull(s.mode)) < {1'b0, WORDS6})
        |=> s.ptr == $past(s.ptr) + 6'(stepFull($past(s.mode)))) // [R13]
        else $error("pointer step wrong");
    ptr_wrap_a: assert property (dataWr
        && ({1'b0, s.ptr} + 7'(stepFull(s.mode)) >= {1'b0, WORDS6})
        |=> s.subCnt == $past(s.subCnt) + 3'h1) // [R25]
        else $error("subaddress counter not bumped on wrap");
    static_bp_a: assert property (s.mode == MODE_STATIC && tick |=> // [R22]
        s.bp[0] == s.bp[1] && s.bp[1] == s.bp[2] && s.bp[2] == s.bp[3])
        else $error("static backplanes differ");
    pair_bp_a: assert property (s.mode == MODE_TWO && tick |=> // [R21]
        s.bp[0] == s.bp[2] && s.bp[1] == s.bp[3])
        else $error("two-backplane pairs differ");
    three_bp_a: assert property (s.mode == MODE_THREE && tick |=> s.bp[3] == s.bp[1]) // [R21]
        else $error("backplane 3 differs from 1");
    sync_reset_a: assert property (syncFall |=> s.phase == 2'($past(s.mode))) // [R16]
        else $error("sync did not reset scan");
    // A mode change may leave the count high until the next tick folds it back
    phase_len_a: assert property (tick |=> s.tickCnt < phaseLen(s.mode) || $changed(s.mode)) // [R1]
        else $error("phase count beyond 24/n");
    freeze_a: assert property (!tick |=> $stable(s.seg) && $stable(s.bp)) // [R3]
        else $error("outputs moved without clock tick");
    off_drive_a: assert property (!s.dispEn && tick |=> s.seg[0] == LVL_VLCD) // [R24]
        else $error("disabled display still driven");
    apb_wait_a: assert property (setupPh |=> pready ##1 !pready)
        else $error("APB answer timing wrong");

endmodule : lrsam_core

`default_nettype wire

// File: lrsam_panel.sv
`timescale 1ns/1ps
`default_nettype none
module lrsam_panel #(
    parameter int HALF = 10
) (
    // Clock and driver pins
    input  wire logic ref_clk,
    input  wire logic clkPinOe,
    input  wire logic clkPinOut,
    input  wire logic syncOe,
    // Request from a cascaded driver
    input  wire logic pullSync,
    // Resolved wires
    output logic      clkPin,
    output var logic  extClk,
    output logic      syncWire_n
);
    int cnt = 0;

    initial extClk = 1'b0;

    // Cascade master clock never pauses; a stalled clock leaves the glass at DC
    always @(posedge ref_clk) begin
        if (cnt == HALF - 1) begin
            cnt <= 0;
            extClk <= ~extClk;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // Pin is shared: whoever enables its driver owns it
    assign clkPin = clkPinOe ? clkPinOut : extClk;
    // Open drain with pull-up, any party may pull low
    assign syncWire_n = ~(syncOe | pullSync);
endmodule : lrsam_panel
`default_nettype wire

// File: lrsam_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module lrsam_core_test;
    import lrsam_pkg::*;
    logic             ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, lastErr;
    logic             oscSel, pullSync, clkPinOut, clkPinOe, syncOut_n, syncOe;
    logic             clkPin, extClk, syncWire_n;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata;
    logic [2:0]       hwSub;
    logic [3:0][1:0]  bpOut;
    logic [39:0][1:0] segOut;
    logic [3:0]       mRam [40];
    logic [5:0]       cfgTbl [6] = '{6'h18, 6'h28, 6'h0D, 6'h39, 6'h0E, 6'h0B};
    int               mPtr, mSub, mMode, mBias, mIn, mOut, lastP;
    int               cyc = 0, errCount = 0, nTests = 0;

    lrsam_core #(.OSC_HALF(4)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .osc_source_select(oscSel),
        .hwSubaddr(hwSub), .clkPinIn(clkPin), .clkPinOut(clkPinOut),
        .clkPinOe(clkPinOe), .syncIn_n(syncWire_n), .syncOut_n(syncOut_n),
        .syncOe(syncOe), .backplane_outputs(bpOut), .segment_outputs(segOut));

    lrsam_panel #(.HALF(10)) i_panel (
        .ref_clk(ref_clk), .clkPinOe(clkPinOe), .clkPinOut(clkPinOut),
        .syncOe(syncOe), .pullSync(pullSync), .clkPin(clkPin), .extClk(extClk),
        .syncWire_n(syncWire_n));

    task automatic completeRun();
        $display("checks %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : completeRun

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int t;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        q = prdata;
        lastErr = pslverr;
        if (t >= 50) errCount++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    // Reference fill: MSB first, rows of one word before the next word
    task automatic model_byte(input logic [7:0] b);
        int n, a, s;
        n = mMode + 1;
        for (int k = 0; k < 8; k++) begin
            a = mPtr + k / n;
            s = mSub;
            if (a > 39) begin
                a -= 40;
                s = (mSub + 1) % 8;
            end
            if (s == hwSub) mRam[a][((mMode < 2 && mIn) ? 2 : 0) + k % n] = b[7 - k];
        end
        mPtr += (mMode == 0) ? 8 : (mMode == 1) ? 4 : (mMode == 2) ? 3 : 2;
        if (mPtr > 39) begin
            mPtr -= 40;
            mSub = (mSub + 1) % 8;
        end
    endtask : model_byte

    // Sample mid-tick so latch and status describe one phase
    task automatic check_disp();
        logic [31:0] st;
        int p, row, act, c;
        @(negedge clkPin);
        repeat (2) @(posedge ref_clk);
        apb(1'b0, OFS_STATUS, 32'h0, st);
        p = int'(st[1:0]);
        check("phase range", 32'(p <= mMode), 1);
        if (lastP >= 0 && p != lastP) check("phase step", st & 32'h3, (lastP + 1) % (mMode + 1));
        lastP = p;
        row = (mMode < 2 && mOut) ? p + 2 : p;
        for (int r = 0; r < 4; r++) begin
            act = mMode == 3 ? r == p : mMode == 2 ? (r == p || (r == 3 && p == 1)) :
                  mMode == 1 ? r % 2 == p : 1;
            c = act ? 3 : 1;
            if (st[2] && (act || mBias)) c = 3 - c;
            check("backplane", 32'(bpOut[r]), c);
        end
        for (int k = 0; k < 40; k++) begin
            c = mRam[k][row] ? 0 : (mBias ? 2 : 3);
            if (st[2]) c = 3 - c;
            check("segment", 32'(segOut[k]), c);
        end
    endtask : check_disp

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errCount++;
            completeRun();
        end
    end

    initial begin
        logic [31:0] q;
        int t;
        time t0;
        void'($urandom(32'h67C8A8ED));
        {reset_n, psel, penable, pwrite, pullSync} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        oscSel = 1'b1;
        hwSub = 3'($urandom_range(7, 0));
        foreach (mRam[k]) mRam[k] = 4'h0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int r = 0; r < 4; r++) check("reset bp", 32'(bpOut[r]), 3);
        for (int k = 0; k < 40; k++) check("reset seg", 32'(segOut[k]), 3);
        check("clock pin input", 32'(clkPinOe), 0);
        check("sync pin level", 32'(syncOut_n), 0);
        apb(1'b0, OFS_CTRL, 32'h0, q);
        check("reset ctrl", q & 32'h3F, 32'h3);
        apb(1'b0, OFS_POINTER, 32'h0, q);
        check("reset pointer", q & 32'h73F, 32'h0);
        apb(1'b0, 8'h10, 32'h0, q);
        check("unmapped err", 32'(lastErr), 1);
        check("unmapped data", q, 32'h0);
        $display("test reset done");
        foreach (cfgTbl[c]) begin
            apb(1'b1, OFS_CTRL, 32'(cfgTbl[c]), q);
            {mOut, mIn} = {int'(cfgTbl[c][5]), int'(cfgTbl[c][4])};
            {mBias, mMode} = {int'(cfgTbl[c][2]), int'(cfgTbl[c][1:0])};
            // Last case starts one device early and crosses into ours mid-stream
            mPtr = (c == 5) ? 36 + $urandom_range(3, 0) : $urandom_range(15, 0);
            mSub = (c == 5) ? (hwSub + 7) % 8 : hwSub;
            apb(1'b1, OFS_POINTER, 32'(mSub * 256 + mPtr), q);
            repeat (3) begin
                t = $urandom_range(255, 0);
                apb(1'b1, OFS_DATA, 32'(t), q);
                model_byte(8'(t));
                apb(1'b0, OFS_POINTER, 32'h0, q);
                check("pointer", q & 32'h73F, 32'(mSub * 256 + mPtr));
            end
            repeat (24) @(posedge clkPin);
            lastP = -1;
            repeat (24) check_disp();
            $display("test mode case %0d done", c);
        end
        do begin
            @(posedge clkPin);
            repeat (3) @(posedge ref_clk);
        end while (syncOe !== 1'b0);
        pullSync <= 1'b1;
        @(posedge ref_clk);
        pullSync <= 1'b0;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, OFS_STATUS, 32'h0, q);
        check("sync phase", q & 32'h3, 32'h3);
        @(posedge syncOe);
        t = 0;
        while (t < 100) begin
            @(posedge clkPin);
            t++;
            repeat (3) @(posedge ref_clk);
            if (syncOe === 1'b1) break;
        end
        check("frame ticks", 32'(t), 24);
        $display("test sync and frame done");
        oscSel <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("clock pin drive", 32'(clkPinOe), 1);
        @(posedge clkPinOut);
        t0 = $time;
        @(negedge clkPinOut);
        check("osc half period", 32'(($time - t0) / 5), 4);
        $display("test oscillator done");
        completeRun();
    end
endmodule : lrsam_core_test
`default_nettype wire
